// ==== src/rtc_defines.vh ====
// register offsets, field positions, unlock keys and timing counts
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
`define OFS_TIME_WIN     12'h000
`define OFS_ALARM_WIN    12'h004
`define OFS_CONFIG       12'h008
`define OFS_UNLOCK       12'h00C
`define OFS_MISC         12'h010
`define BIT_ENABLE       15
`define BIT_WREN         13
`define BIT_SYNC         12
`define BIT_HALF_SECOND_STATUS      11
`define BIT_OE           10
`define UNLOCK_KEY1      16'h0055
`define UNLOCK_KEY2      16'h00AA
`define CLK_HZ           20000000
`define HALF_SEC_CYCLES  (`CLK_HZ / 2)
`define SYNC_WINDOW      32
`define CAL_PERIOD       120
`endif

// ==== src/rtc_calendar.v ====
// real-time clock and calendar with pointer windows on an apb slave
`include "rtc_defines.vh"
module rtc_calendar #(
	parameter HALF_CYCLES = `HALF_SEC_CYCLES
) (
	// clock and resets
	input  wire        mclk,
	input  wire        reset,
	input  wire        ext_reset_pin,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// clock output pin
	output reg         clock_pin
);
	// bcd increment by one, no wrap; callers wrap to their low value
	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction
	// days in a month, bcd month, leap flag
	function [7:0] month_days;
		input [7:0] m;
		input       leap;
		begin
			case (m)
			8'h02: month_days = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
			default: month_days = 8'h31;
			endcase
		end
	endfunction
	// 24-hour bcd to 12-hour bcd with pm in bit 7
	function [7:0] hour12;
		input [7:0] h;
		reg   [7:0] t;
		begin
			t = h;
			if (h == 8'h00)
				t = 8'h12;
			else if (h > 8'h12)
				t = (h[3:0] >= 4'h2) ? {h[7:4] - 4'h1, h[3:0] - 4'h2}
					: {h[7:4] - 4'h2, h[3:0] + 4'h8};
			hour12 = {(h >= 8'h12), t[6:0]};
		end
	endfunction

	wire [4:0] yr_lo;
	wire       leap;
	// register and decode helpers
	wire       setup    = psel && !penable;
	wire       access   = psel && penable;
	wire       do_write = access && pwrite;
	wire       do_read  = access && !pwrite;
	// time fields, bcd
	reg  [7:0] seconds, minutes, hours, weekday, day, month, year;
	// alarm fields, bcd
	reg  [7:0] al_sec, al_min, al_hr, al_wd, al_day, al_mon;
	reg  [1:0] time_window_pointer;
	reg  [1:0] alarm_window_pointer;
	reg        clock_module_enable;
	reg        value_write_enable;
	reg        clock_pin_output_enable;
	reg        clock_pin_source_select;
	reg        hour_mode_24;
	reg        alarm_enable;
	reg  [7:0] calibration;
	reg        half_second_status;
	reg  [31:0] div_cnt;
	reg  [7:0] cal_min;
	reg  [1:0] unlock_state;
	reg  [1:0] ext_sync;
	reg        alarm_pulse;

	assign yr_lo = year[4] ? 5'd10 + {1'b0, year[3:0]} : {1'b0, year[3:0]};
	// 2000..2099: leap when year divisible by four
	assign leap = (yr_lo[1:0] == 2'b00);

	// pipeline the external reset pin; it never stops the clock
	always @(posedge mclk) begin
		if (reset)
			ext_sync <= 2'b00;
		else
			ext_sync <= {ext_sync[0], ext_reset_pin};
	end

	// half-second tick with calibration trim each minute
	wire signed [7:0] cal_s   = calibration;
	wire [31:0]       trim    = {{24{cal_s[7]}}, cal_s};
	wire              trim_on = (seconds == 8'h00) && !half_second_status;
	wire [31:0]       limit   = trim_on ? HALF_CYCLES - 32'd1 - trim
		: HALF_CYCLES - 32'd1;
	wire              half_tick = clock_module_enable && (div_cnt >= limit);
	wire              sec_tick  = half_tick && half_second_status;
	wire              sync_zone = clock_module_enable && half_second_status &&
		(div_cnt + `SYNC_WINDOW >= limit);

	// window writes allowed with write enable only
	wire win_we  = do_write && value_write_enable;
	wire t_hit   = paddr == `OFS_TIME_WIN;
	wire a_hit   = paddr == `OFS_ALARM_WIN;
	wire wr_hi   = pstrb[1];
	wire wr_lo   = pstrb[0];
	wire [7:0] wd_hi = pwdata[15:8];
	wire [7:0] wd_lo = pwdata[7:0];

	// timekeeping and time window writes
	always @(posedge mclk) begin
		if (reset) begin
			div_cnt <= 32'h0;
			half_second_status <= 1'b0;
			seconds <= 8'h00;
			minutes <= 8'h00;
			hours   <= 8'h00;
			weekday <= 8'h06; // 2000-01-01 was a saturday
			day     <= 8'h01;
			month   <= 8'h01;
			year    <= 8'h00;
		end else begin
			if (half_tick) begin
				div_cnt <= 32'h0;
				half_second_status <= !half_second_status;
			end else if (clock_module_enable)
				div_cnt <= div_cnt + 32'h1;
			if (sec_tick) begin
				seconds <= (seconds == 8'h59) ? 8'h00 : bcd_inc(seconds);
				if (seconds == 8'h59) begin
					minutes <= (minutes == 8'h59) ? 8'h00 : bcd_inc(minutes);
					if (minutes == 8'h59) begin
						hours <= (hours == 8'h23) ? 8'h00 : bcd_inc(hours);
						if (hours == 8'h23) begin
							weekday <= (weekday == 8'h06) ? 8'h00
								: weekday + 8'h01;
							if (day == month_days(month, leap)) begin
								day <= 8'h01;
								month <= (month == 8'h12) ? 8'h01
									: bcd_inc(month);
								if (month == 8'h12)
									year <= (year == 8'h99) ? 8'h00
										: bcd_inc(year);
							end else
								day <= bcd_inc(day);
						end
					end
				end
			end
			if (win_we && t_hit) begin
				case (time_window_pointer)
				2'b00: begin
					if (wr_hi) minutes <= wd_hi;
					if (wr_lo) seconds <= wd_lo;
				end
				2'b01: begin
					if (wr_hi) weekday <= wd_hi;
					if (wr_lo) hours <= wd_lo;
				end
				2'b10: begin
					if (wr_hi) month <= wd_hi;
					if (wr_lo) day <= wd_lo;
				end
				default: begin
					if (wr_lo) year <= wd_lo;
				end
				endcase
			end
		end
	end

	// alarm window writes and alarm match
	always @(posedge mclk) begin
		if (reset) begin
			al_sec <= 8'h00;
			al_min <= 8'h00;
			al_hr  <= 8'h00;
			al_wd  <= 8'h00;
			al_day <= 8'h01;
			al_mon <= 8'h01;
			alarm_pulse <= 1'b0;
		end else begin
			if (win_we && a_hit) begin
				case (alarm_window_pointer)
				2'b00: begin
					if (wr_hi) al_min <= wd_hi;
					if (wr_lo) al_sec <= wd_lo;
				end
				2'b01: begin
					if (wr_hi) al_wd <= wd_hi;
					if (wr_lo) al_hr <= wd_lo;
				end
				2'b10: begin
					if (wr_hi) al_mon <= wd_hi;
					if (wr_lo) al_day <= wd_lo;
				end
				default: ;
				endcase
			end
			// one pulse lasting half a second on a full match
			if (half_tick)
				alarm_pulse <= alarm_enable && half_second_status &&
					seconds == al_sec && minutes == al_min &&
					hours == al_hr && weekday == al_wd &&
					day == al_day && month == al_mon;
		end
	end

	// pointer stepping: upper-byte writes and any read
	wire t_step = access && t_hit && (!pwrite || wr_hi);
	wire a_step = access && a_hit && (!pwrite || wr_hi);
	wire cfg_wr = do_write && paddr == `OFS_CONFIG;
	wire key_wr = do_write && paddr == `OFS_UNLOCK;

	// configuration, pointers and unlock sequence
	always @(posedge mclk) begin
		if (reset) begin
			time_window_pointer <= 2'b00;
			alarm_window_pointer <= 2'b00;
			clock_module_enable <= 1'b0;
			value_write_enable <= 1'b0;
			clock_pin_output_enable <= 1'b0;
			calibration <= 8'h00;
			unlock_state <= 2'd0;
			clock_pin_source_select <= 1'b0;
			hour_mode_24 <= 1'b1;
			alarm_enable <= 1'b0;
		end else begin
			// unlock: key1, key2, then next access only
			if (key_wr && pwdata[15:0] == `UNLOCK_KEY1)
				unlock_state <= 2'd1;
			else if (key_wr && pwdata[15:0] == `UNLOCK_KEY2 &&
				unlock_state == 2'd1)
				unlock_state <= 2'd2;
			else if (access)
				unlock_state <= 2'd0;
			if (cfg_wr) begin
				clock_module_enable <= pwdata[`BIT_ENABLE];
				clock_pin_output_enable <= pwdata[`BIT_OE];
				time_window_pointer <= pwdata[9:8];
				calibration <= pwdata[7:0];
				if (!pwdata[`BIT_WREN])
					value_write_enable <= 1'b0;
				else if (unlock_state == 2'd2)
					value_write_enable <= 1'b1;
			end else if (t_step && time_window_pointer != 2'b00)
				time_window_pointer <= time_window_pointer - 2'b01;
			if (do_write && paddr == `OFS_MISC) begin
				clock_pin_source_select <= pwdata[0];
				hour_mode_24 <= pwdata[1];
				alarm_enable <= pwdata[2];
				alarm_window_pointer <= pwdata[9:8];
			end else if (a_step && alarm_window_pointer != 2'b00)
				alarm_window_pointer <= alarm_window_pointer - 2'b01;
		end
	end

	// read mux
	reg [31:0] rd;
	always @* begin
		rd = 32'h0;
		case (paddr)
		`OFS_TIME_WIN:
			case (time_window_pointer)
			2'b00: rd = {16'h0, minutes, seconds};
			2'b01: rd = {16'h0, weekday,
				hour_mode_24 ? hours : hour12(hours)};
			2'b10: rd = {16'h0, month, day};
			default: rd = {24'h0, year};
			endcase
		`OFS_ALARM_WIN:
			case (alarm_window_pointer)
			2'b00: rd = {16'h0, al_min, al_sec};
			2'b01: rd = {16'h0, al_wd, al_hr};
			2'b10: rd = {16'h0, al_mon, al_day};
			default: rd = 32'h0;
			endcase
		`OFS_CONFIG:
			rd = {16'h0, clock_module_enable, 1'b0, value_write_enable,
				sync_zone, half_second_status,
				clock_pin_output_enable, time_window_pointer, calibration};
		`OFS_MISC:
			rd = {22'h0, alarm_window_pointer, 5'h0, alarm_enable,
				hour_mode_24, clock_pin_source_select};
		default: rd = 32'h0;
		endcase
	end

	// apb answer: no wait states, error on unmapped address
	wire mapped = t_hit || a_hit || paddr == `OFS_CONFIG ||
		paddr == `OFS_UNLOCK || paddr == `OFS_MISC;
	always @(posedge mclk) begin
		if (reset) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
				prdata <= rd;
		end
	end

	// output pin source and enable
	always @(posedge mclk) begin
		if (reset)
			clock_pin <= 1'b0;
		else
			clock_pin <= clock_pin_output_enable &&
				(clock_pin_source_select ? !half_second_status
				: alarm_pulse);
	end
endmodule

// ==== dv/rtc_calendar_assertions.sv ====
// port checker for the calendar block, bound to its top
module rtc_calendar_assertions #(
	parameter HALF_CYCLES = 8
) (
	// clock and resets
	input wire        mclk,
	input wire        reset,
	input wire        ext_reset_pin,
	// apb slave
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// clock output pin
	input wire        clock_pin
);
	logic oe;
	int   hi;
	wire  mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// track pin enable and the length of each high run
	always @(posedge mclk) begin
		if (reset)
			oe <= 1'b0;
		else if (psel && penable && pwrite && pready && paddr == 12'h008)
			oe <= pwdata[10];
		hi <= (reset || !clock_pin) ? 0 : hi + 1;
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_idle_no_ready: assert property (!psel |=> !pready)
		else $error("ready without select");
	a_err_unmapped: assert property (psel && !penable && !mapped |=> pslverr && pready)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (psel && !penable && mapped |=> !pslverr)
		else $error("mapped access refused");
	a_reset_quiet: assert property (disable iff (1'b0) reset |=> !pready && !pslverr && !clock_pin)
		else $error("outputs active after reset");
	a_pin_needs_oe: assert property (!oe && !$past(oe) |-> !clock_pin)
		else $error("pin active while disabled");
	a_tick_half_sec: assert property (hi <= HALF_CYCLES)
		else $error("pin high longer than half second");
	c_write: cover property (pready && pwrite);
	c_read: cover property (pready && !pwrite);
	c_tick: cover property ($rose(clock_pin));
endmodule
bind rtc_calendar rtc_calendar_assertions #(.HALF_CYCLES(HALF_CYCLES)) chk (
	.mclk          (mclk),
	.reset         (reset),
	.ext_reset_pin (ext_reset_pin),
	.psel          (psel),
	.penable       (penable),
	.pwrite        (pwrite),
	.paddr         (paddr),
	.pwdata        (pwdata),
	.pstrb         (pstrb),
	.prdata        (prdata),
	.pready        (pready),
	.pslverr       (pslverr),
	.clock_pin     (clock_pin)
);

// ==== dv/rtc_calendar_tb.sv ====
// self-checking bench for the calendar block over apb
module rtc_calendar_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 0, reset = 1, ext_reset_pin = 0;
	logic        psel = 0, penable = 0, pwrite = 0, lp = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  pstrb = 0;
	logic        pready, pslverr, clock_pin, er;
	int          errors = 0, num_checks = 0, cyc = 0, rises = 0;
	int          hs = 0, sy = 0;
	rtc_calendar #(.HALF_CYCLES(8)) DUT (
		.mclk          (mclk),
		.reset         (reset),
		.ext_reset_pin (ext_reset_pin),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.pstrb         (pstrb),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.clock_pin     (clock_pin)
	);
	always #25 mclk = ~mclk;
	// cycle limit and tick counter
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (clock_pin && !lp)
			rises <= rises + 1;
		lp <= clock_pin;
		if (cyc == 4000) begin
			errors++;
			results();
		end
	end
	task results;
		$display("errors=%0d checks=%0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// one apb transfer, held until ready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, 4'h3);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(0, a, 32'h0, 4'h0);
		check(rd & m, e);
	endtask
	task unlock;
		wr(12'h00C, 32'h55);
		wr(12'h00C, 32'hAA);
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 0;
		rdc(12'h010, 32'h2, 32'h2);
		unlock();
		wr(12'h008, 32'h2300);
		rdc(12'h008, 32'h2300, 32'h2300);
		wr(12'h000, 32'h0024);
		wr(12'h000, 32'h0229);
		wr(12'h000, 32'h0421);
		wr(12'h000, 32'h5958);
		wr(12'h000, 32'h5958);
		rdc(12'h008, 32'h0300, 32'h0);
		wr(12'h008, 32'h2100);
		apb(1, 12'h000, 32'h0023, 4'h1);
		rdc(12'h008, 32'h0300, 32'h0100);
		wr(12'h008, 32'h2300);
		rdc(12'h000, 32'hFFFF, 32'h0024);
		rdc(12'h000, 32'hFFFF, 32'h0229);
		rdc(12'h000, 32'hFFFF, 32'h0423);
		rdc(12'h000, 32'hFFFF, 32'h5958);
		rdc(12'h000, 32'hFFFF, 32'h5958);
		wr(12'h008, 32'h2100);
		wr(12'h010, 32'h0);
		rdc(12'h000, 32'hFFFF, 32'h0491);
		wr(12'h010, 32'h0202);
		wr(12'h004, 32'h0301);
		wr(12'h004, 32'h0500);
		wr(12'h004, 32'h0008);
		rdc(12'h010, 32'h0300, 32'h0);
		wr(12'h010, 32'h0302);
		rdc(12'h004, 32'hFFFF, 32'h0);
		rdc(12'h004, 32'hFFFF, 32'h0301);
		rdc(12'h004, 32'hFFFF, 32'h0500);
		rdc(12'h004, 32'hFFFF, 32'h0008);
		wr(12'h008, 32'h0);
		wr(12'h000, 32'h1111);
		rdc(12'h000, 32'hFFFF, 32'h5958);
		unlock();
		rdc(12'h010, 32'h7, 32'h2);
		wr(12'h008, 32'h2000);
		rdc(12'h008, 32'h2000, 32'h0);
		check(er, 1'b0);
		apb(0, 12'h014, 32'h0, 4'h0);
		check(er, 1'b1);
		apb(1, 12'h100, 32'h0, 4'h3);
		check(er, 1'b1);
		wr(12'h010, 32'h3);
		wr(12'h008, 32'h8600);
		ext_reset_pin <= 1;
		rises = 0;
		// 16 reads, 3 cycles apart, hit every phase of a second once
		repeat (16) begin
			apb(0, 12'h008, 32'h0, 4'h0);
			hs += rd[11];
			sy += rd[12];
		end
		ext_reset_pin <= 0;
		check(hs, 8);
		check(sy, 8);
		check(rises > 1, 1);
		rdc(12'h000, 32'hFFFF, 32'h0301);
		rdc(12'h000, 32'hFFFF, 32'h0500);
		wr(12'h008, 32'h8000);
		// let the last registered pin level drain before counting
		repeat (2) @(posedge mclk);
		rises = 0;
		repeat (40) @(posedge mclk);
		check(rises, 0);
		// alarm on the pin: full match at 03-01 weekday 05 00:00:08
		wr(12'h010, 32'h6);
		wr(12'h008, 32'h8400);
		repeat (2) @(posedge mclk);
		rises = 0;
		repeat (100) @(posedge mclk);
		check(rises, 1);
		results();
	end
endmodule
